// File: common/wdt_consts.vh
// constants for the watchdog and power/reset unit
// assumes a 32-bit ahb-lite register bus and one clock
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH
// offsets are word indexes: byte address is four times the index
`define OFF_WDT_CTRL 8'h8f
`define OFF_PWR_CTRL 8'h87
`define OFF_IRQ_STAT 8'h90
`define OFF_IRQ_MASK 8'h94
`define OFF_RST_CTRL 8'h98
`define WDT_CTRL_RESET 8'h00
`define PWR_CTRL_RESET 8'h00
`define PWR_CTRL_POR 8'h10
`define PWR_CTRL_KEEP 8'h10
`define PWR_CTRL_WMASK 8'h1f
`define BIT_WDT_EN 7
`define BIT_WDT_CLR 6
`define BIT_WDT_IDLE 3
`define BIT_POWER_OFF 4
`define BIT_POWER_DOWN_REQ 1
`define BIT_IDLE_REQ 0
`define PORT_RESET 8'hff
`define SP_RESET 8'h07
`define OSC_DIV 2
`define MC_DIV 12
`define RST_MIN_MC 2
`define DEGLITCH_LEN 4
`define WRST_LEN 5'd24
`endif

// File: core/watchdog_power_reset_unit.v
// watchdog, idle/power-down control and reset sampling of the core
// assumes hclk is the oscillator, ahb-lite master, synchronous inputs
//
// Summary of operation
// - counter runs only while the enable bit is one
// - writing clear bit resets counter, prescaler and itself at the next machine cycle
// - counts in idle only when the idle-enable bit is one
// - three-bit select picks prescaler 2 to 256 by doubling
// - time-out is 12 times prescaler times 2^14 oscillator periods
// - code 000 gives 19.66 ms at 20 MHz, doubling per code
// - any reset clears counter, prescaler and control register
// - time-out while enabled causes a full system reset
// - oscillator divided by two before internal use
// - idle stops only the processor clock, peripherals keep running
// - enabled interrupt or reset ends idle
// - power-down stops all clocks, only reset ends it
// - external reset sampled at state5_phase2, held two machine cycles
// - short reset glitches are filtered out
// - reset sets ports ffh, stack pointer 07h, others 00h except the power-off flag and, on watchdog or pin reset, irq mask and status
// - power-off flag set on power-on, cleared only by software
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_consts.vh"
module watchdog_power_reset_unit #(
	parameter CNT_W = 14,
	parameter PRE_W = 8
) (
	// bus
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// system
	input wire ext_reset,
	input wire irq_pending,
	output reg sys_reset,
	output reg cpu_clk_en,
	output reg periph_clk_en,
	output reg osc_run,
	output reg [7:0] port_reset_val,
	output reg [7:0] sp_reset_val,
	output reg irq
);
	reg [7:0] wdt_ctrl_q;
	reg [7:0] pwr_ctrl_q;
	reg [1:0] irq_stat_q;
	reg [1:0] irq_mask_q;
	reg [CNT_W-1:0] cnt_q;
	reg [PRE_W-1:0] pre_q;
	reg half_q;
	reg [3:0] mc_q;
	reg [3:0] rst_sh_q;
	reg [2:0] ext_hi_q;
	reg [4:0] wrst_q;
	reg wr_pend_q;
	reg [7:0] wr_addr_q;
	reg clr_pend_q;
	reg [PRE_W-1:0] pre_lim;
	reg [31:0] rd_d;
	wire half_tick = half_q;
	wire mc_tick = half_tick && (mc_q == 4'd5);
	wire state5_phase2 = half_tick && (mc_q == 4'd4);
	wire idle_now = pwr_ctrl_q[`BIT_IDLE_REQ];
	wire power_down_now = pwr_ctrl_q[`BIT_POWER_DOWN_REQ];
	// a steady reset level restarts the stopped oscillator, else power-down could never end
	wire osc_wake = &rst_sh_q;
	wire cpu_run = !idle_now && !power_down_now;
	wire run = wdt_ctrl_q[`BIT_WDT_EN] && !power_down_now && (!idle_now || wdt_ctrl_q[`BIT_WDT_IDLE]);
	wire timeout = run && mc_tick && (pre_q == pre_lim) && (&cnt_q);
	wire ext_ok = (ext_hi_q >= `RST_MIN_MC);
	wire any_rst = (wrst_q != 5'd0) || ext_ok;
	wire wdt_fire = (wrst_q == `WRST_LEN);
	wire addr_ph = hsel && hready && htrans[1];
	wire [31:0] wd = hwdata;
	wire [31:0] cnt_ext = {{(32-CNT_W){1'b0}}, cnt_q};
	wire [CNT_W-1:0] cnt_one = {{(CNT_W-1){1'b0}}, 1'b1};
	wire [PRE_W-1:0] pre_one = {{(PRE_W-1){1'b0}}, 1'b1};
	// writes land on the data phase, one cycle after the address
	wire stat_wr = wr_pend_q && (wr_addr_q == `OFF_IRQ_STAT) && !any_rst;
	wire [1:0] irq_clr = stat_wr ? wd[1:0] : 2'b00;
	wire [1:0] irq_set = {idle_now && irq_pending && !any_rst, wdt_fire};
	wire [1:0] irq_live = irq_stat_q & irq_mask_q;
	genvar g;
	// oscillator halved; a stopped oscillator freezes everything downstream
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			half_q <= 1'b0;
		else
			half_q <= ~half_q & ~(power_down_now && !osc_wake);
	end
	// machine cycle of six states, two phases each
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			mc_q <= 4'd0;
		else if (half_tick)
			mc_q <= (mc_q == 4'd5) ? 4'd0 : mc_q + 4'd1;
	end
	// prescale ratio doubles per select code, limit is the ratio minus one
	always @*
	begin
		pre_lim = 8'd255;
		case (wdt_ctrl_q[2:0])
		3'd0: pre_lim = 8'd1;
		3'd1: pre_lim = 8'd3;
		3'd2: pre_lim = 8'd7;
		3'd3: pre_lim = 8'd15;
		3'd4: pre_lim = 8'd31;
		3'd5: pre_lim = 8'd63;
		3'd6: pre_lim = 8'd127;
		default: pre_lim = 8'd255;
		endcase
	end
	// reset pin filter, sampled once per machine cycle
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rst_sh_q <= 4'h0;
			ext_hi_q <= 3'd0;
		end
		else
		begin
			rst_sh_q <= {rst_sh_q[2:0], ext_reset};
			if (state5_phase2)
			begin
				if (&rst_sh_q)
					ext_hi_q <= (ext_hi_q == 3'd7) ? ext_hi_q : ext_hi_q + 3'd1;
				else if (~|rst_sh_q)
					ext_hi_q <= 3'd0;
			end
		end
	end
	// watchdog reset stretch, two machine cycles like an external reset
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wrst_q <= 5'd0;
		else if (timeout)
			wrst_q <= `WRST_LEN;
		else if (wrst_q != 5'd0)
			wrst_q <= wrst_q - 5'd1;
	end
	// read mux on the word index; low address bits ignored
	always @*
	begin
		rd_d = 32'h0;
		case (haddr[9:2])
		`OFF_WDT_CTRL: rd_d = {24'h0, wdt_ctrl_q};
		`OFF_PWR_CTRL: rd_d = {24'h0, pwr_ctrl_q};
		`OFF_IRQ_STAT: rd_d = {30'h0, irq_stat_q};
		`OFF_IRQ_MASK: rd_d = {30'h0, irq_mask_q};
		`OFF_RST_CTRL: rd_d = cnt_ext;
		default: rd_d = 32'h0;
		endcase
	end
	// bus data phase
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wr_pend_q <= addr_ph && hwrite;
			if (addr_ph)
				wr_addr_q <= haddr[9:2];
			if (addr_ph && !hwrite)
				hrdata <= rd_d;
		end
	end
	// watchdog counter and prescaler; wraps through the time-out, the reset clears it anyway
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_q <= {CNT_W{1'b0}};
			pre_q <= {PRE_W{1'b0}};
		end
		else if (any_rst || (clr_pend_q && mc_tick))
		begin
			cnt_q <= {CNT_W{1'b0}};
			pre_q <= {PRE_W{1'b0}};
		end
		else if (run && mc_tick)
		begin
			if (pre_q == pre_lim)
			begin
				pre_q <= {PRE_W{1'b0}};
				cnt_q <= cnt_q + cnt_one;
			end
			else
				pre_q <= pre_q + pre_one;
		end
	end
	// control registers
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wdt_ctrl_q <= `WDT_CTRL_RESET;
			pwr_ctrl_q <= `PWR_CTRL_POR; // power-on sets flag
			irq_mask_q <= 2'b00;
			clr_pend_q <= 1'b0;
		end
		else if (any_rst)
		begin
			wdt_ctrl_q <= `WDT_CTRL_RESET;
			pwr_ctrl_q <= pwr_ctrl_q & `PWR_CTRL_KEEP; // flag kept
			clr_pend_q <= 1'b0;
		end
		else
		begin
			// clear bit reads back as one until the next machine cycle
			if (clr_pend_q && mc_tick)
			begin
				clr_pend_q <= 1'b0;
				wdt_ctrl_q[`BIT_WDT_CLR] <= 1'b0;
			end
			if (idle_now && irq_pending)
				pwr_ctrl_q[`BIT_IDLE_REQ] <= 1'b0;
			if (wr_pend_q)
			begin
				case (wr_addr_q)
				`OFF_WDT_CTRL:
				begin
					wdt_ctrl_q <= {wd[7:6], 2'b00, wd[3], wd[2:0]} | {1'b0, clr_pend_q && !mc_tick, 6'h0};
					if (wd[`BIT_WDT_CLR])
						clr_pend_q <= 1'b1;
				end
				`OFF_PWR_CTRL: pwr_ctrl_q <= wd[7:0] & `PWR_CTRL_WMASK; // software clear
				`OFF_IRQ_MASK: irq_mask_q <= wd[1:0];
				default: ;
				endcase
			end
		end
	end
	// one sticky status bit per event; set wins over write-one clear
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : stat_bit
			always @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					irq_stat_q[g] <= 1'b0;
				else
					irq_stat_q[g] <= (irq_stat_q[g] & ~irq_clr[g]) | irq_set[g];
			end
		end
	endgenerate
	// clock enables, reset level and interrupt
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sys_reset <= 1'b1;
			cpu_clk_en <= 1'b0;
			periph_clk_en <= 1'b0;
			osc_run <= 1'b1;
			irq <= 1'b0;
		end
		else
		begin
			sys_reset <= any_rst;
			cpu_clk_en <= cpu_run && half_tick;
			periph_clk_en <= !power_down_now && half_tick;
			osc_run <= !power_down_now;
			irq <= |irq_live;
		end
	end
	// port and stack reset values; flops only so every output is registered
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			port_reset_val <= `PORT_RESET;
			sp_reset_val <= `SP_RESET;
		end
		else
		begin
			port_reset_val <= `PORT_RESET;
			sp_reset_val <= `SP_RESET;
		end
	end
endmodule // watchdog_power_reset_unit
`default_nettype wire

// File: tb/testbench.sv
// bench of the watchdog power reset unit
// assumes zero-wait bus answers
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_reset = 0, irq_pending = 0;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	wire logic [31:0] hrdata;
	wire logic hreadyout, hresp, sys_reset, cpu_clk_en, periph_clk_en, osc_run, irq;
	wire logic [7:0] port_reset_val, sp_reset_val;
	int errors = 0, cmp_count = 0, n, k;
	// short counter keeps time-outs brief
	watchdog_power_reset_unit #(.CNT_W(4)) watchdog_power_reset_unit_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .ext_reset, .irq_pending,
		.sys_reset, .cpu_clk_en, .periph_clk_en, .osc_run, .port_reset_val, .sp_reset_val, .irq);
	always #20 hclk = ~hclk;
	task finish_test;
		if (errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task hold;
		n = 0;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 9);
		if (n > 8)
		begin
			errors++;
			finish_test();
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {22'h000000, a, 2'b00};
		hwrite <= w;
		htrans <= 2'h2;
		hold();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hold();
		rd = hrdata;
	endtask
	task wait_rst(input logic v, input int lim);
		n = 0;
		while (sys_reset !== v && n < lim)
		begin
			@(posedge hclk);
			n++;
		end
	endtask
	task t_reset;
		bus(1'b0, 8'h8f, '0);
		chk("ctl", '0, rd);
		bus(1'b0, 8'h87, '0);
		chk("pwr", 32'h10, rd);
		bus(1'b0, 8'ha0, '0);
		chk("unmapped", '0, rd);
		chk("resp", '0, {31'h0, hresp});
		chk("ports sp", 32'hff07, {16'h0000, port_reset_val, sp_reset_val});
	endtask
	task t_timeout;
		// one doubling per select code
		for (k = 0; k < 3; k++)
		begin
			bus(1'b1, 8'h8f, 32'hc0 | k);
			wait_rst(1'b1, (384 << k) + 40);
			chk("time-out", 1, {31'h0, n > (384 << k) - 20 && sys_reset});
			wait_rst(1'b0, 99);
			chk("reset length", 1, {31'h0, n > 22});
			bus(1'b0, 8'h8f, '0);
			chk("ctl", '0, rd);
		end
	endtask
	task t_irq;
		bus(1'b1, 8'h94, 1);
		repeat (2) @(posedge hclk);
		chk("irq on", 1, {31'h0, irq});
		bus(1'b1, 8'h94, '0);
		repeat (2) @(posedge hclk);
		chk("irq masked", '0, {31'h0, irq});
		bus(1'b1, 8'h94, 1);
		bus(1'b1, 8'h90, 1);
		repeat (2) @(posedge hclk);
		chk("irq cleared", '0, {31'h0, irq});
	endtask
	task t_guard;
		repeat (4)
		begin
			bus(1'b1, 8'h8f, 32'hc0);
			wait_rst(1'b1, 300);
			chk("cleared", '0, {31'h0, sys_reset});
		end
		bus(1'b1, 8'h87, 1);
		wait_rst(1'b1, 1000);
		chk("idle halt", '0, {31'h0, sys_reset});
		irq_pending <= 1'b1;
		bus(1'b1, 8'h8f, '0);
		irq_pending <= 1'b0;
		wait_rst(1'b1, 1000);
		chk("disabled", '0, {31'h0, sys_reset});
		bus(1'b0, 8'h87, '0);
		chk("idle left", '0, rd);
		bus(1'b0, 8'h90, '0);
		chk("wake stat", 32'h2, rd);
	endtask
	task t_power;
		ext_reset <= 1'b1;
		@(posedge hclk);
		ext_reset <= 1'b0;
		wait_rst(1'b1, 60);
		chk("glitch", '0, {31'h0, sys_reset});
		bus(1'b1, 8'h87, '0);
		bus(1'b1, 8'h87, 2);
		irq_pending <= 1'b1;
		repeat (20) @(posedge hclk);
		chk("osc off", '0, {31'h0, osc_run});
		irq_pending <= 1'b0;
		ext_reset <= 1'b1;
		wait_rst(1'b1, 60);
		ext_reset <= 1'b0;
		wait_rst(1'b0, 99);
		chk("osc back", 1, {31'h0, osc_run});
		bus(1'b0, 8'h87, '0);
		chk("pwr kept", '0, rd);
	endtask
	initial
	begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_timeout();
		t_irq();
		t_guard();
		t_power();
		finish_test();
	end
endmodule // testbench
`default_nettype wire

// File: tb/wpr_properties.sv
// assertions on the watchdog power reset unit ports
// assumes one clock and a bind onto the unit
`timescale 1ns/10ps
`default_nettype none
module wpr_props (
	// inputs
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ext_reset,
	input wire logic irq_pending,
	// outputs
	input wire logic sys_reset,
	input wire logic cpu_clk_en,
	input wire logic periph_clk_en,
	input wire logic osc_run
);
	// run length of the reset pin, saturating
	reg [5:0] ext_q;
	always @(posedge hclk or negedge hresetn)
		if (!hresetn)
			ext_q <= 6'h00;
		else
			ext_q <= ext_reset ? ext_q + {5'h00, ~&ext_q} : 6'h00;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_half_rate: assert property (periph_clk_en |=> !periph_clk_en) else $error("rate");
	a_idle_cpu: assert property (cpu_clk_en |-> periph_clk_en) else $error("idle");
	a_wake_irq: assert property (osc_run && irq_pending && !sys_reset ##1 osc_run |-> ##[0:6] cpu_clk_en)
		else $error("wake");
	a_power_down_stop: assert property (!osc_run |-> !periph_clk_en) else $error("stop");
	a_power_down_hold: assert property (!osc_run && !ext_reset |=> !osc_run || sys_reset) else $error("hold");
	a_ext_taken: assert property (ext_q == 6'd48 |-> sys_reset) else $error("taken");
	a_glitch_free: assert property (!sys_reset && $rose(ext_reset) ##1 !ext_reset |-> !sys_reset [*6]) else $error("glitch");
	a_reset_len: assert property ($rose(sys_reset) |-> sys_reset [*8]) else $error("length");
	cover property ($rose(sys_reset));
	cover property (periph_clk_en && !cpu_clk_en);
	cover property ($fell(osc_run));
endmodule // wpr_props
bind watchdog_power_reset_unit wpr_props wpr_props_i (.hclk, .hresetn, .ext_reset, .irq_pending, .sys_reset,
	.cpu_clk_en, .periph_clk_en, .osc_run);
`default_nettype wire
